// file: core/qeo_encoder.sv
// readhead end: ring motion steps to quadrature and reference outputs
// Function
// - complementary copies on A, B and reference
// - edges per revolution = interp times poles
// - edge rate follows ring step rate
// - one reference pulse per revolution
// - forward motion: A rises before B
// - receiver counts up when A leads
// - no direction inversion setting exists
// - reference outputs only on reference variant
// - reference lasts one step, edge aligned
// - lamp lit while reference pole sensed
// - receiver leaves pitch/interp scaling to software
// - receiver uses complements or insulates
// - receiver homes on reference pulse
`timescale 1ns/1ps
`default_nettype none
module qeo_encoder #(
  parameter int unsigned INTERP  = qeo_pkg::INTERP_DEF,
  parameter int unsigned POLES   = qeo_pkg::POLES_DEF,
  parameter bit          HAS_REF = 1'b1
) (
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  step_i,
  input  wire logic  dir_rev_i,
  output logic       ref_lamp_o,
  output logic [qeo_pkg::EDGE_W-1:0] angle_o,
  qeo_link_if.enc    link
);
  // edges per revolution, derived not stored
  localparam int unsigned EDGES = INTERP * POLES;
  localparam logic [qeo_pkg::EDGE_W-1:0] LAST =
    qeo_pkg::EDGE_W'(EDGES - 1);
  localparam logic [qeo_pkg::EDGE_W-1:0] ZERO = '0;
  localparam logic [qeo_pkg::EDGE_W-1:0] ONE  =
    qeo_pkg::EDGE_W'(1);
  // reference pole spans one quadrature cycle at angle zero
  localparam logic [qeo_pkg::EDGE_W-1:0] POLE_SPAN =
    qeo_pkg::EDGE_W'(qeo_pkg::STEPS_PER_CYCLE);
  // limitation: phase and angle stay locked only when the edge
  // count is a multiple of four, as it is for real rings

  // slots of the three channels in the true and complement vectors
  localparam int unsigned CH_A   = 0;
  localparam int unsigned CH_B   = 1;
  localparam int unsigned CH_Z   = 2;
  localparam int unsigned CH_NUM = 3;

  // bit slots and gray levels {a, b} of the decoded phase
  localparam int unsigned AB_A   = 1;
  localparam int unsigned AB_B   = 0;
  localparam logic [1:0]  AB_00  = 2'h0;
  localparam logic [1:0]  AB_10  = 2'h2;
  localparam logic [1:0]  AB_11  = 2'h3;
  localparam logic [1:0]  AB_01  = 2'h1;

  // reset parks the head on the reference step, so the outputs
  // already show that step and no false reference edge follows
  localparam logic        Z_RST    = HAS_REF;
  localparam logic        LAMP_RST = 1'b1;
  localparam qeo_pkg::qeo_phase_t PH_RST =
    qeo_pkg::qeo_phase_t'(qeo_pkg::PH_REF);

  // ring position, phase and the registered pin levels
  logic [qeo_pkg::EDGE_W-1:0] ang_q;
  logic [qeo_pkg::EDGE_W-1:0] ang_d;
  qeo_pkg::qeo_phase_t        ph_q;
  qeo_pkg::qeo_phase_t        ph_d;
  qeo_pkg::qeo_phase_t        ph_fwd;
  qeo_pkg::qeo_phase_t        ph_rev;
  logic [1:0]                 ab_d;
  logic                       a_q;
  logic                       b_q;
  logic                       z_q;
  logic                       lamp_q;
  wire  [CH_NUM-1:0]          ch_true;
  wire  [CH_NUM-1:0]          ch_comp;

  // direction comes only from motion sense, no inversion input
  wire fwd = ~dir_rev_i;
  wire at_top = (ang_q == LAST);
  wire at_bot = (ang_q == ZERO);
  // wrap at both ends keeps one revolution exactly EDGES steps
  wire [qeo_pkg::EDGE_W-1:0] ang_inc = at_top ? ZERO : ang_q + ONE;
  wire [qeo_pkg::EDGE_W-1:0] ang_dec = at_bot ? LAST : ang_q - ONE;

  // successor and predecessor of the current phase
  always_comb begin
    case (ph_q)
      qeo_pkg::QEO_PH_00: begin
        ph_fwd = qeo_pkg::QEO_PH_10;
        ph_rev = qeo_pkg::QEO_PH_01;
      end
      qeo_pkg::QEO_PH_10: begin
        ph_fwd = qeo_pkg::QEO_PH_11;
        ph_rev = qeo_pkg::QEO_PH_00;
      end
      qeo_pkg::QEO_PH_11: begin
        ph_fwd = qeo_pkg::QEO_PH_01;
        ph_rev = qeo_pkg::QEO_PH_10;
      end
      qeo_pkg::QEO_PH_01: begin
        ph_fwd = qeo_pkg::QEO_PH_00;
        ph_rev = qeo_pkg::QEO_PH_11;
      end
      default: begin
        ph_fwd = PH_RST;
        ph_rev = PH_RST;
      end
    endcase
  end

  // one step of motion moves exactly one measuring step
  always_comb begin
    ang_d = ang_q;
    ph_d  = ph_q;
    if (step_i) begin
      if (fwd) begin
        ang_d = ang_inc;
        ph_d  = ph_fwd;
      end else begin
        ang_d = ang_dec;
        ph_d  = ph_rev;
      end
    end
  end

  // gray decode: 00,10,11,01 so A rises before B going forward
  // decoding the next phase keeps the pins in step with the angle
  always_comb begin
    case (ph_d)
      qeo_pkg::QEO_PH_00: ab_d = AB_00;
      qeo_pkg::QEO_PH_10: ab_d = AB_10;
      qeo_pkg::QEO_PH_11: ab_d = AB_11;
      qeo_pkg::QEO_PH_01: ab_d = AB_01;
      default:            ab_d = AB_00;
    endcase
  end

  // neighbouring phases differ in one bit only
  wire a_d = ab_d[AB_A];
  wire b_d = ab_d[AB_B];
  wire in_pole_d = (ang_d < POLE_SPAN);
  // pulse only in the one step inside the pole where phase is 00
  wire home_step_d = (ang_d == ZERO);
  wire z_d = HAS_REF & home_step_d;
  // without reference the lamp only shows that power is up
  wire lamp_d = HAS_REF ? in_pole_d : 1'b1;

  // motion state: angle and phase move together
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ang_q <= ZERO;
      ph_q  <= PH_RST;
    end else begin
      ang_q <= ang_d;
      ph_q  <= ph_d;
    end
  end

  // phase lines come from flops so no decode glitch reaches a pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_q <= AB_00[AB_A];
      b_q <= AB_00[AB_B];
    end else begin
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  // reference pulse and lamp
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      z_q    <= Z_RST;
      lamp_q <= LAMP_RST;
    end else begin
      z_q    <= z_d;
      lamp_q <= lamp_d;
    end
  end

  assign ch_true[CH_A] = a_q;
  assign ch_true[CH_B] = b_q;
  // without reference the true line is driven low, not released
  assign ch_true[CH_Z] = HAS_REF & z_q;

  // one inverter per channel; a missing reference keeps both lines low
  for (genvar i = 0; i < CH_NUM; i++) begin : g_comp
    localparam bit LIVE = (i != CH_Z) || HAS_REF;
    assign ch_comp[i] = LIVE & ~ch_true[i];
  end

  // the link carries the true levels straight from the flops, complements via one inverter each
  assign link.ch_a    = ch_true[CH_A];
  assign link.ch_a_n  = ch_comp[CH_A];
  assign link.ch_b    = ch_true[CH_B];
  assign link.ch_b_n  = ch_comp[CH_B];
  assign link.ch_z    = ch_true[CH_Z];
  assign link.ch_z_n  = ch_comp[CH_Z];
  assign link.ch_z_en = HAS_REF;
  assign ref_lamp_o   = lamp_q;
  assign angle_o      = ang_q;
endmodule
`default_nettype wire

// file: include/qeo_pkg.sv
// shared constants and types for the quadrature encoder output link
`default_nettype none
package qeo_pkg;
  // measuring steps per quadrature cycle
  localparam int unsigned STEPS_PER_CYCLE = 4;
  // default interpolation factor and ring pole count
  localparam int unsigned INTERP_DEF      = 16;
  localparam int unsigned POLES_DEF       = 64;
  localparam int unsigned EDGE_W          = 24;
  localparam int unsigned POS_W           = 32;
  // quadrature phase states, gray order, forward walks upward
  typedef enum logic [1:0] {
    QEO_PH_00 = 2'b00,
    QEO_PH_10 = 2'b01,
    QEO_PH_11 = 2'b10,
    QEO_PH_01 = 2'b11
  } qeo_phase_t;
  localparam logic [1:0] PH_STEP_FWD = 2'h1;
  localparam logic [1:0] PH_REF      = 2'h0;
endpackage
`default_nettype wire

// file: include/qeo_link_if.sv
// quadrature link between encoder readhead and receiving counter
`timescale 1ns/1ps
`default_nettype none
interface qeo_link_if;
  logic ch_a;
  logic ch_a_n;
  logic ch_b;
  logic ch_b_n;
  logic ch_z;
  logic ch_z_n;
  logic ch_z_en;
  modport enc (output ch_a, ch_a_n, ch_b, ch_b_n, ch_z, ch_z_n, ch_z_en);
  modport rcv (input  ch_a, ch_a_n, ch_b, ch_b_n, ch_z, ch_z_n, ch_z_en);
endinterface
`default_nettype wire

// file: core/qeo_counter.sv
// receiving end: x4 quadrature decode, position and reference homing
`timescale 1ns/1ps
`default_nettype none
module qeo_counter (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     home_arm_i,
  output logic [qeo_pkg::POS_W-1:0]     pos_o,
  output logic                          homed_o,
  output logic                          pair_err_o,
  qeo_link_if.rcv                       link
);
  logic [1:0]                  ab_q;
  logic [qeo_pkg::POS_W-1:0]   pos_q;
  logic                        homed_q;
  logic                        err_q;
  logic                        armed_q;
  logic                        seen_q;

  wire [1:0] ab   = {link.ch_a, link.ch_b};
  // gray step forward: 00->10->11->01->00, A leading
  wire fwd = (ab_q == 2'h0 && ab == 2'h2) | (ab_q == 2'h2 && ab == 2'h3) |
             (ab_q == 2'h3 && ab == 2'h1) | (ab_q == 2'h1 && ab == 2'h0);
  wire rev = (ab == 2'h0 && ab_q == 2'h2) | (ab == 2'h2 && ab_q == 2'h3) |
             (ab == 2'h3 && ab_q == 2'h1) | (ab == 2'h1 && ab_q == 2'h0);
  // complements checked against true lines
  wire bad = (link.ch_a == link.ch_a_n) | (link.ch_b == link.ch_b_n) |
             (link.ch_z_en & (link.ch_z == link.ch_z_n));
  wire zero_hit = link.ch_z_en & link.ch_z & armed_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ab_q    <= 2'h0;
      pos_q   <= '0;
      homed_q <= 1'b0;
      err_q   <= 1'b0;
      armed_q <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      ab_q  <= ab;
      err_q <= bad;
      seen_q <= 1'b1;
      armed_q <= home_arm_i | (armed_q & ~zero_hit);
      if (zero_hit) begin
        pos_q   <= '0;
        homed_q <= 1'b1;
      end else if (seen_q & fwd) begin
        pos_q <= pos_q + qeo_pkg::POS_W'(1);
      end else if (seen_q & rev) begin
        pos_q <= pos_q - qeo_pkg::POS_W'(1);
      end
    end
  end
  // metric scaling left to software using pitch/interp
  assign pos_o      = pos_q;
  assign homed_o    = homed_q;
  assign pair_err_o = err_q;
endmodule
`default_nettype wire

// file: dv/qeo_link_properties.sv
// assertions on the quadrature link between the two ends
`timescale 1ns/1ps
`default_nettype none
module qeo_link_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ch_a,
  input wire logic ch_a_n,
  input wire logic ch_b,
  input wire logic ch_b_n,
  input wire logic ch_z,
  input wire logic ch_z_n,
  input wire logic ch_z_en
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  comp_a_a: assert property (ch_a_n != ch_a)
    else $error("a complement wrong");
  comp_b_a: assert property (ch_b_n != ch_b)
    else $error("b complement wrong");
  comp_z_a: assert property (ch_z_en |-> ch_z_n != ch_z)
    else $error("z complement wrong");
  z_off_a: assert property (!ch_z_en |-> !ch_z && !ch_z_n)
    else $error("z driven without reference");
  one_step_a: assert property (!($changed(ch_a) && $changed(ch_b)))
    else $error("a and b switched together");
  z_home_a: assert property (ch_z |-> !ch_a && !ch_b)
    else $error("z outside home step");
  z_rise_a: assert property ($rose(ch_z) |-> $changed({ch_a, ch_b}))
    else $error("z rise not edge aligned");
  z_fall_a: assert property ($fell(ch_z) |-> $changed({ch_a, ch_b}))
    else $error("z fall not edge aligned");
  cover property ($rose(ch_z));
  cover property ($rose(ch_a) && !ch_b);
  cover property ($rose(ch_b) && !ch_a);
endmodule
`default_nettype wire

// file: dv/quadrature_encoder_output_tb.sv
// self-checking bench: both link ends joined, random ring motion
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_output_tb;
  // small ring keeps one revolution short
  localparam int INTERP = 2;
  localparam int POLES = 4;
  localparam int N = INTERP * POLES;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic step_i = 1'b0;
  logic dir_rev_i = 1'b0;
  logic home_arm_i = 1'b0;
  logic ref_lamp_o, homed_o, pair_err_o;
  logic [qeo_pkg::EDGE_W-1:0] angle_o;
  logic [qeo_pkg::POS_W-1:0] pos_o;
  logic [15:0] lfsr = 16'h9193;
  int miscompares = 0, samples_checked = 0, ang = 0, net = 0, zs = 0;
  qeo_link_if link ();
  qeo_link_if link_nr ();
  logic nr_lamp;
  wire [3:0] obs = {link.ch_a, link.ch_b, link.ch_z, ref_lamp_o};
  qeo_encoder #(.INTERP(INTERP), .POLES(POLES), .HAS_REF(1'b1))
    qeo_encoder_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .step_i(step_i),
    .dir_rev_i(dir_rev_i), .ref_lamp_o(ref_lamp_o), .angle_o(angle_o),
    .link(link));
  // variant without reference, same motion
  qeo_encoder #(.INTERP(INTERP), .POLES(POLES), .HAS_REF(1'b0))
    qeo_encoder_nr_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .step_i(step_i), .dir_rev_i(dir_rev_i), .ref_lamp_o(nr_lamp),
    .angle_o(), .link(link_nr));
  qeo_counter qeo_counter_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .home_arm_i(home_arm_i), .pos_o(pos_o), .homed_o(homed_o),
    .pair_err_o(pair_err_o), .link(link));
  qeo_link_properties qeo_link_properties_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ch_a(link.ch_a), .ch_a_n(link.ch_a_n),
    .ch_b(link.ch_b), .ch_b_n(link.ch_b_n), .ch_z(link.ch_z),
    .ch_z_n(link.ch_z_n), .ch_z_en(link.ch_z_en));
  always #5 clk_i = ~clk_i;
  always @(posedge link.ch_z) if (rst_n_i) zs++;
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // expected {a, b, z, lamp}: forward walks 00, 10, 11, 01
  function automatic logic [3:0] exp_out(int a);
    int m = a % qeo_pkg::STEPS_PER_CYCLE;
    return {m == 1 || m == 2, m >= 2, a == 0, a < qeo_pkg::STEPS_PER_CYCLE};
  endfunction
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // check last step's outcome, then launch the next one
  task automatic cyc(logic s, logic d);
    @(negedge clk_i);
    chk("angle", ang, angle_o);
    chk("out", exp_out(ang), obs);
    chk("err", 0, pair_err_o);
    chk("noref ab", exp_out(ang) >> 2, {link_nr.ch_a, link_nr.ch_b});
    chk("noref z", 4'h1, {link_nr.ch_z, link_nr.ch_z_n, link_nr.ch_z_en,
      nr_lamp});
    step_i = s;
    dir_rev_i = d;
    if (s) begin
      ang = d ? (ang + N - 1) % N : (ang + 1) % N;
      net += d ? -1 : 1;
    end
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) cyc(0, 0);
    repeat (N) cyc(1, 0);
    cyc(0, 0);
    chk("zcount", 1, zs);
    $display("test revolution done");
    for (int i = 0; i < 300; i++) begin
      lfsr = nxt(lfsr);
      cyc(lfsr[0] | lfsr[5], lfsr[3]);
    end
    repeat (3) cyc(0, 0);
    chk("pos", net, pos_o);
    chk("homed", 0, homed_o);
    $display("test random done");
    home_arm_i = 1'b1;
    cyc(1, 0);
    for (int i = 0; i < N && ang != 0; i++) cyc(1, 0);
    for (int i = 0; i < 8 && homed_o !== 1'b1; i++) cyc(0, 0);
    repeat (3) cyc(0, 0);
    chk("homed", 1, homed_o);
    chk("pos home", 0, pos_o);
    $display("test homing done");
    summarize();
  end
endmodule
`default_nettype wire
